// ==== design/prs_cycle_gen.sv ====
/*
  machine cycle state generator: six states of two oscillator periods.
  assumes the enable is low while clocks are stopped.
*/
`timescale 1ns/10ps
`include "prs_regs.svh"
module prs_cycle_gen
  import prs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // control
  input wire logic run_en,
  // state outputs
  output prs_state_t state_r,
  output logic phase2_r,
  output logic cycle_end_r
);
  prs_state_t state_nxt;
  wire last_phase = phase2_r && (state_r == PRS_S6);

  always_comb begin
    case (state_r)
      PRS_S1: state_nxt = PRS_S2;
      PRS_S2: state_nxt = PRS_S3;
      PRS_S3: state_nxt = PRS_S4;
      PRS_S4: state_nxt = PRS_S5;
      PRS_S5: state_nxt = PRS_S6;
      PRS_S6: state_nxt = PRS_S1;
      default: state_nxt = PRS_S1;
    endcase
  end

  // [R1] six two-phase states
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= PRS_S1;
      phase2_r <= 1'b0;
      cycle_end_r <= 1'b0;
    end else if (run_en) begin
      phase2_r <= ~phase2_r;
      if (phase2_r) begin
        state_r <= state_nxt;
      end
      cycle_end_r <= last_phase;
    end else begin
      cycle_end_r <= 1'b0;
    end
  end
endmodule

// ==== design/prs_pkg.sv ====
/*
  types shared by the sequencer modules.
  assumes nothing beyond a systemverilog compiler.
*/
package prs_pkg;
  typedef enum logic [2:0] {
    PRS_RUN = 3'b001,
    PRS_IDLE = 3'b010,
    PRS_PDOWN = 3'b100
  } prs_mode_t;
  typedef enum logic [5:0] {
    PRS_S1 = 6'b000001,
    PRS_S2 = 6'b000010,
    PRS_S3 = 6'b000100,
    PRS_S4 = 6'b001000,
    PRS_S5 = 6'b010000,
    PRS_S6 = 6'b100000
  } prs_state_t;
endpackage

// ==== design/prs_regs.svh ====
/*
  timing and reset constants for the power and reset sequencer.
  assumes inclusion from design files only.
*/
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
`define PRS_STATES_PER_CYCLE 6
`define PRS_OSC_PER_STATE 2
`define PRS_OSC_PER_CYCLE 12
`define PRS_RST_SAMPLE_CYCLES 2
`define PRS_WDT_HOLD_CYCLES 2
`define PRS_EXT_HOLD_CYCLES 2
`define PRS_RESET_PC 16'h0000
`define PRS_RESET_SP 8'h07
`define PRS_RESET_PORT 8'hff
`define PRS_IDLE_BIT 0
`define PRS_PD_BIT 1
`define PRS_FLASH_SWRST_MASK 8'h83
`define PRS_WDT_TIMEOUT 20'h0ffff
`endif

// ==== design/prs_sequencer.sv ====
/*
  machine cycle timing, fetch schedule, idle and power-down control and
  reset sequencing for an 8-bit controller core.
  assumes the core supplies decode hints and register write strobes on
  ref_clk; reset pin and interrupt pins are asynchronous.
*/
// What this block does
// [R1] machine cycle is six states, each two oscillator periods, twelve total
// [R2] two fetches per cycle; unneeded fetch discarded, program counter held
// [R3] single-cycle op: opcode latch in S1, second fetch S4, done end S6
// [R4] external data move takes two cycles, no fetch in the second
// [R5] fetch timing identical for internal and external program memory
// [R6] program read strobe twice per cycle, two skipped during data access
// [R7] writing idle request bit enters idle after that instruction
// [R8] idle stops cpu clock, peripherals keep running, state held
// [R9] enabled interrupt clears idle bit, ends idle, runs handler
// [R10] pin, power-on or watchdog reset ends idle without delay
// [R11] writing powerdown request bit stops all clocks, ports held
// [R12] reset pin high in power-down restarts at 0000h; watchdog cannot
// [R13] enabled level-mode external pin with global enable wakes power-down
// [R14] after power-down wake handler, execution continues at next instruction
// [R15] reset pin sampled at state5 phase2; held two cycles to count
// [R16] internal reset from pin applied synchronously, needs running clock
// [R17] reset held while pin high plus two cycles, no cause flag
// [R18] flash control bits 0,1,7 set give software reset, loader to app
// [R19] watchdog free runs, cleared restarts, timeout flags, optional reset
// [R20] watchdog reset held two machine cycles, then start at 0000h
// [R21] reset forces program counter 0000h, stack pointer 07h
// [R22] reset clears special registers, ports 0ffh, watchdog off after power-on
// [R23] each external interrupt has its own edge or level select
// [R24] global enable clear masks every interrupt
// [R25] any reset clears idle and power-down request bits
`timescale 1ns/10ps
`include "prs_regs.svh"
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int WDT_TIMEOUT = `PRS_WDT_TIMEOUT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // pins
  input wire logic reset_pin,
  input wire logic ext_int0_n,
  input wire logic ext_int1_n,
  // core hints
  input wire logic needs_code_byte,
  input wire logic ext_data_move,
  input wire logic insn_last_cycle,
  input wire logic other_int_req,
  input wire logic ext_prog_mem,
  input wire logic in_loader_flash,
  // power control register write
  input wire logic power_control_register_wr,
  input wire logic [7:0] power_control_register_wdata,
  // flash control register write
  input wire logic flash_ctl_wr,
  input wire logic [7:0] flash_ctl_wdata,
  // interrupt configuration
  input wire logic global_interrupt_enable,
  input wire logic ext_int0_enable,
  input wire logic ext_int1_enable,
  input wire logic ext_int0_trigger_select,
  input wire logic ext_int1_trigger_select,
  // watchdog control
  input wire logic wdt_enable_set,
  input wire logic wdt_clear,
  input wire logic wdt_reset_enable,
  input wire logic wdt_flag_clear,
  // status and timing outputs
  output prs_mode_t mode_r,
  output logic idle_request_bit_r,
  output logic powerdown_request_bit_r,
  output logic cpu_clk_en_r,
  output logic periph_clk_en_r,
  output logic core_reset_r,
  output logic opcode_latch_r,
  output logic fetch_r,
  output logic pc_inc_r,
  output logic program_read_strobe_r,
  output logic insn_done_r,
  output logic wake_int_r,
  output logic resume_next_r,
  output logic app_flash_sel_r,
  output logic wdt_flag_r,
  output logic wdt_enabled_r,
  output logic [15:0] pc_load_r,
  output logic [7:0] sp_load_r,
  output logic [7:0] port_load_r
);
  prs_state_t state;
  logic phase2;
  logic cycle_end;
  logic run_en;
  logic [2:0] rst_sync_r;
  logic [2:0] int0_sync_r;
  logic [2:0] int1_sync_r;
  logic rst_lvl_r;
  logic int0_n_lvl_r;
  logic int1_n_lvl_r;
  logic int0_prev_r;
  logic int1_prev_r;
  logic [1:0] rst_hits_r;
  logic [1:0] hold_cnt_r;
  logic second_move_r;
  logic [19:0] wdt_cnt_r;
  logic wdt_rst_pend_r;

  // oscillator-domain state counter keeps running in idle
  assign run_en = (mode_r != PRS_PDOWN);
  prs_cycle_gen u_cycle (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run_en(run_en),
    .state_r(state),
    .phase2_r(phase2),
    .cycle_end_r(cycle_end)
  );

  // three-stage pin synchronisers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 3'h0;
      int0_sync_r <= 3'h7;
      int1_sync_r <= 3'h7;
    end else begin
      rst_sync_r <= {rst_sync_r[1:0], reset_pin};
      int0_sync_r <= {int0_sync_r[1:0], ext_int0_n};
      int1_sync_r <= {int1_sync_r[1:0], ext_int1_n};
    end
  end

  // level changes only when stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_lvl_r <= 1'b0;
      int0_n_lvl_r <= 1'b1;
      int1_n_lvl_r <= 1'b1;
    end else begin
      if (rst_sync_r[1] == rst_sync_r[2]) begin
        rst_lvl_r <= rst_sync_r[2];
      end
      if (int0_sync_r[1] == int0_sync_r[2]) begin
        int0_n_lvl_r <= int0_sync_r[2];
      end
      if (int1_sync_r[1] == int1_sync_r[2]) begin
        int1_n_lvl_r <= int1_sync_r[2];
      end
    end
  end

  // decode of timing points
  wire state5_phase2 = (state == PRS_S5) && phase2;
  wire state6_phase2 = (state == PRS_S6) && phase2;
  wire s1p1 = (state == PRS_S1) && !phase2;
  wire s4p1 = (state == PRS_S4) && !phase2;
  wire in_pd = (mode_r == PRS_PDOWN);
  wire in_idle = (mode_r == PRS_IDLE);

  // [R23] edge or level per input
  wire int0_edge = int0_prev_r && !int0_n_lvl_r;
  wire int1_edge = int1_prev_r && !int1_n_lvl_r;
  wire int0_act = ext_int0_trigger_select ? int0_edge : !int0_n_lvl_r;
  wire int1_act = ext_int1_trigger_select ? int1_edge : !int1_n_lvl_r;
  // [R24] global enable gates all
  wire any_int = global_interrupt_enable &&
                 ((ext_int0_enable && int0_act) || (ext_int1_enable && int1_act) ||
                  other_int_req);
  // [R13] level-mode wake only
  wire pd_wake = global_interrupt_enable &&
                 ((ext_int0_enable && !ext_int0_trigger_select && !int0_n_lvl_r) ||
                  (ext_int1_enable && !ext_int1_trigger_select && !int1_n_lvl_r));

  // [R12] pin reset acts in power-down too
  wire pin_rst_pd = in_pd && rst_lvl_r;
  // [R15] sampled at state5_phase2
  wire pin_rst_ok = (rst_hits_r == 2'd`PRS_RST_SAMPLE_CYCLES) ||
                    pin_rst_pd;
  // [R18] software reset loader to app only
  wire sw_rst = flash_ctl_wr && in_loader_flash &&
                ((flash_ctl_wdata & `PRS_FLASH_SWRST_MASK) == `PRS_FLASH_SWRST_MASK);
  // [R19] timeout while watchdog enabled
  wire wdt_timeout = wdt_enabled_r && (wdt_cnt_r == 20'(WDT_TIMEOUT));
  wire any_rst = pin_rst_ok || sw_rst || wdt_rst_pend_r;
  wire idle_wr = power_control_register_wr && power_control_register_wdata[`PRS_IDLE_BIT];
  wire pd_wr = power_control_register_wr && power_control_register_wdata[`PRS_PD_BIT];

  // reset pin sample count and edge memories
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_hits_r <= 2'd0;
      int0_prev_r <= 1'b1;
      int1_prev_r <= 1'b1;
    end else begin
      if (state5_phase2) begin
        int0_prev_r <= int0_n_lvl_r;
        int1_prev_r <= int1_n_lvl_r;
        if (!rst_lvl_r) begin
          rst_hits_r <= 2'd0;
        end else if (rst_hits_r != 2'd`PRS_RST_SAMPLE_CYCLES) begin
          rst_hits_r <= rst_hits_r + 2'd1;
        end
      end
    end
  end

  // [R16] synchronous internal reset
  // [R17] stretch two cycles after release
  // [R20] watchdog reset held two cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      core_reset_r <= 1'b1;
      hold_cnt_r <= 2'd`PRS_EXT_HOLD_CYCLES;
    end else if (any_rst) begin
      core_reset_r <= 1'b1;
      hold_cnt_r <= 2'd`PRS_WDT_HOLD_CYCLES;
    end else if (core_reset_r && cycle_end) begin
      if (hold_cnt_r == 2'd0) begin
        core_reset_r <= 1'b0;
      end else begin
        hold_cnt_r <= hold_cnt_r - 2'd1;
      end
    end
  end

  // [R7] idle and power-down entry
  // [R8] clock enables change with the mode
  // [R25] reset clears request bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= PRS_RUN;
      cpu_clk_en_r <= 1'b1;
      periph_clk_en_r <= 1'b1;
      idle_request_bit_r <= 1'b0;
      powerdown_request_bit_r <= 1'b0;
      wake_int_r <= 1'b0;
      resume_next_r <= 1'b0;
    end else begin
      wake_int_r <= 1'b0;
      resume_next_r <= 1'b0;
      if (any_rst) begin
        // [R10] reset ends idle immediately
        mode_r <= PRS_RUN;
        cpu_clk_en_r <= 1'b1;
        periph_clk_en_r <= 1'b1;
        idle_request_bit_r <= 1'b0;
        powerdown_request_bit_r <= 1'b0;
      end else if (in_pd) begin
        // [R14] resume after the entering instruction
        if (pd_wake) begin
          mode_r <= PRS_RUN;
          cpu_clk_en_r <= 1'b1;
          periph_clk_en_r <= 1'b1;
          powerdown_request_bit_r <= 1'b0;
          wake_int_r <= 1'b1;
          resume_next_r <= 1'b1;
        end
      end else if (in_idle) begin
        // [R9] interrupt ends idle
        if (any_int) begin
          mode_r <= PRS_RUN;
          cpu_clk_en_r <= 1'b1;
          idle_request_bit_r <= 1'b0;
          wake_int_r <= 1'b1;
        end
      end else begin
        if (pd_wr) begin
          powerdown_request_bit_r <= 1'b1;
        end else if (idle_wr) begin
          idle_request_bit_r <= 1'b1;
        end
        // [R11] power-down wins over idle
        if (insn_last_cycle && state6_phase2 && powerdown_request_bit_r) begin
          mode_r <= PRS_PDOWN;
          cpu_clk_en_r <= 1'b0;
          periph_clk_en_r <= 1'b0;
        end else if (insn_last_cycle && state6_phase2 && idle_request_bit_r) begin
          mode_r <= PRS_IDLE;
          cpu_clk_en_r <= 1'b0;
        end
      end
    end
  end

  // [R4] track second cycle of data move
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second_move_r <= 1'b0;
    end else if (core_reset_r) begin
      second_move_r <= 1'b0;
    end else if (state6_phase2 && cpu_clk_en_r) begin
      second_move_r <= ext_data_move && !second_move_r;
    end
  end

  // [R2] two fetches, surplus discarded
  // [R3] opcode at S1, fetch at S4
  // [R5] same timing for any memory
  // [R6] strobe only for external memory
  // a reset taken on this edge already silences the strobes
  wire cpu_live = cpu_clk_en_r && !core_reset_r && !any_rst;
  wire fetch_slot = cpu_live && !second_move_r && (s1p1 || s4p1);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opcode_latch_r <= 1'b0;
      fetch_r <= 1'b0;
      pc_inc_r <= 1'b0;
      program_read_strobe_r <= 1'b0;
      insn_done_r <= 1'b0;
    end else begin
      opcode_latch_r <= fetch_slot && s1p1;
      fetch_r <= fetch_slot;
      pc_inc_r <= fetch_slot && (s1p1 || needs_code_byte);
      program_read_strobe_r <= fetch_slot && ext_prog_mem;
      insn_done_r <= cpu_live && state6_phase2 && insn_last_cycle;
    end
  end

  // [R19] free-running watchdog
  // [R22] watchdog off after power-on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_cnt_r <= 20'h0;
      wdt_flag_r <= 1'b0;
      wdt_enabled_r <= 1'b0;
      wdt_rst_pend_r <= 1'b0;
    end else begin
      wdt_rst_pend_r <= 1'b0;
      if (wdt_enable_set) begin
        wdt_enabled_r <= 1'b1;
      end
      // [R12] watchdog frozen in power-down
      if (wdt_clear || !wdt_enabled_r) begin
        wdt_cnt_r <= 20'h0;
      end else if (!in_pd && cycle_end) begin
        if (wdt_timeout) begin
          wdt_cnt_r <= 20'h0;
          wdt_rst_pend_r <= wdt_reset_enable;
        end else begin
          wdt_cnt_r <= wdt_cnt_r + 20'h1;
        end
      end
      if (!in_pd && cycle_end && wdt_timeout && !wdt_clear) begin
        wdt_flag_r <= 1'b1;
      end else if (wdt_flag_clear) begin
        wdt_flag_r <= 1'b0;
      end
    end
  end

  // [R21] reset load values
  // [R18] application flash select
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_load_r <= `PRS_RESET_PC;
      sp_load_r <= `PRS_RESET_SP;
      port_load_r <= `PRS_RESET_PORT;
      app_flash_sel_r <= 1'b0;
    end else begin
      pc_load_r <= `PRS_RESET_PC;
      sp_load_r <= `PRS_RESET_SP;
      port_load_r <= `PRS_RESET_PORT;
      if (sw_rst) begin
        app_flash_sel_r <= 1'b1;
      end
    end
  end
endmodule

// ==== testbench/prs_ext_src.sv ====
/*
  far side model: external reset source and interrupt pins.
  assumes the testbench calls its tasks; pins change on falling edges.
*/
`timescale 1ns/10ps
module prs_ext_src (
  // clock
  input wire logic ref_clk,
  // pins
  output logic reset_pin,
  output logic ext_int0_n,
  output logic ext_int1_n
);
  initial begin
    reset_pin = 1'b0;
    ext_int0_n = 1'b1;
    ext_int1_n = 1'b1;
  end
  task automatic hold_reset(input int n);
    @(negedge ref_clk);
    reset_pin = 1'b1;
    repeat ((n < 24) ? 24 : n) @(negedge ref_clk);
    reset_pin = 1'b0;
  endtask
  // level request held until released
  task automatic drive_int(input logic which, input logic lvl);
    @(negedge ref_clk);
    if (which) ext_int1_n = lvl;
    else ext_int0_n = lvl;
  endtask
endmodule

// ==== testbench/prs_sequencer_chk.sv ====
/*
  concurrent checks on the sequencer top ports.
  assumes a bind from the testbench top and a single clock domain.
*/
`timescale 1ns/10ps
module prs_sequencer_chk
  import prs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // requests
  input wire logic power_control_register_wr,
  input wire logic [7:0] power_control_register_wdata,
  input wire logic flash_ctl_wr,
  input wire logic [7:0] flash_ctl_wdata,
  input wire logic in_loader_flash,
  // status
  input wire prs_mode_t mode_r,
  input wire logic idle_request_bit_r,
  input wire logic powerdown_request_bit_r,
  input wire logic cpu_clk_en_r,
  input wire logic periph_clk_en_r,
  input wire logic core_reset_r,
  input wire logic fetch_r,
  input wire logic program_read_strobe_r,
  input wire logic insn_done_r,
  input wire logic [15:0] pc_load_r,
  input wire logic [7:0] sp_load_r,
  input wire logic [7:0] port_load_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_run_wr;
    power_control_register_wr && mode_r == PRS_RUN && !core_reset_r;
  endsequence
  sequence s_held_reset;
    core_reset_r ##1 core_reset_r;
  endsequence
  property p_fetch_gap;
    fetch_r |=> !fetch_r [*5];
  endproperty
  property p_strobe_gap;
    program_read_strobe_r |=> !program_read_strobe_r [*5];
  endproperty
  property p_reset_quiet;
    core_reset_r |-> !fetch_r && !insn_done_r;
  endproperty
  property p_stopped_nofetch;
    mode_r != PRS_RUN |-> !fetch_r;
  endproperty
  property p_idle_bit;
    s_run_wr and (power_control_register_wdata[0] && !power_control_register_wdata[1])
      |=> idle_request_bit_r;
  endproperty
  property p_pd_bit;
    s_run_wr and power_control_register_wdata[1] |=> powerdown_request_bit_r;
  endproperty
  property p_idle_clk;
    mode_r == PRS_IDLE |-> !cpu_clk_en_r && periph_clk_en_r;
  endproperty
  property p_pd_clk;
    mode_r == PRS_PDOWN |-> !cpu_clk_en_r && !periph_clk_en_r;
  endproperty
  property p_reset_clears;
    s_held_reset |-> !idle_request_bit_r && !powerdown_request_bit_r;
  endproperty
  property p_sw_reset;
    flash_ctl_wr && (flash_ctl_wdata & 8'h83) == 8'h83 && in_loader_flash
      |-> ##[1:40] core_reset_r;
  endproperty
  property p_load_vals;
    pc_load_r == 16'h0000 && sp_load_r == 8'h07 && port_load_r == 8'hff;
  endproperty
  a_fetch_gap: assert property (p_fetch_gap) else $error("fetch too close");
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe too close");
  a_reset_quiet: assert property (p_reset_quiet) else $error("fetch in reset");
  a_stopped_nofetch: assert property (p_stopped_nofetch) else $error("fetch stopped");
  a_idle_bit: assert property (p_idle_bit) else $error("idle bit not set");
  a_pd_bit: assert property (p_pd_bit) else $error("powerdown bit not set");
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock gating");
  a_pd_clk: assert property (p_pd_clk) else $error("powerdown clock gating");
  a_reset_clears: assert property (p_reset_clears) else $error("bits kept in reset");
  a_sw_reset: assert property (p_sw_reset) else $error("no software reset");
  a_load_vals: assert property (p_load_vals) else $error("reset load values");
endmodule

// ==== testbench/prs_sequencer_tb.sv ====
/*
  self-checking bench for the power and reset sequencer.
  assumes the design and its package compile first; watchdog count shortened.
*/
`timescale 1ns/10ps
module prs_sequencer_tb;
  import prs_pkg::*;
  logic ref_clk, rstn, reset_pin, ext_int0_n, ext_int1_n;
  logic needs_code_byte, ext_data_move, insn_last_cycle, other_int_req;
  logic ext_prog_mem, in_loader_flash, power_control_register_wr, flash_ctl_wr;
  logic [7:0] power_control_register_wdata, flash_ctl_wdata;
  logic global_interrupt_enable, ext_int0_enable, ext_int1_enable;
  logic ext_int0_trigger_select, ext_int1_trigger_select;
  logic wdt_enable_set, wdt_clear, wdt_reset_enable, wdt_flag_clear;
  prs_mode_t mode_r;
  logic idle_request_bit_r, powerdown_request_bit_r, cpu_clk_en_r, periph_clk_en_r;
  logic core_reset_r, opcode_latch_r, fetch_r, pc_inc_r, program_read_strobe_r;
  logic insn_done_r, wake_int_r, resume_next_r, app_flash_sel_r, wdt_flag_r;
  logic wdt_enabled_r;
  logic [15:0] pc_load_r;
  logic [7:0] sp_load_r, port_load_r;
  int err_total, checks_done, n_f, n_s, n_p, n_o, n_d, k;
  prs_sequencer #(.WDT_TIMEOUT(8)) prs_sequencer_inst (.*);
  prs_ext_src prs_ext_src_inst (.ref_clk(ref_clk), .reset_pin(reset_pin),
    .ext_int0_n(ext_int0_n), .ext_int1_n(ext_int1_n));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // sel 0 writes power control, 1 writes flash control
  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge ref_clk);
    power_control_register_wr = !sel;
    flash_ctl_wr = sel;
    power_control_register_wdata = d;
    flash_ctl_wdata = d;
    @(negedge ref_clk);
    {power_control_register_wr, flash_ctl_wr} = 2'b00;
  endtask
  task automatic wait_mode(input prs_mode_t m);
    k = 0;
    while (mode_r !== m && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    chk("mode", mode_r, m);
  endtask
  task automatic wait_reset(input logic v);
    k = 0;
    while (core_reset_r !== v && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    chk("core_reset", core_reset_r, v);
  endtask
  task automatic count_fetch(input int n);
    {n_f, n_s, n_p, n_o, n_d} = '0;
    repeat (n) begin
      @(negedge ref_clk);
      n_f += (fetch_r === 1'b1);
      n_o += (opcode_latch_r === 1'b1);
      n_d += (insn_done_r === 1'b1);
      n_s += (program_read_strobe_r === 1'b1);
      n_p += (pc_inc_r === 1'b1);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #300us;
    err_total++;
    complete_run();
  end
  initial begin
    {rstn, needs_code_byte, ext_data_move, other_int_req, ext_prog_mem} = '0;
    {in_loader_flash, power_control_register_wr, flash_ctl_wr} = '0;
    {power_control_register_wdata, flash_ctl_wdata} = '0;
    {global_interrupt_enable, ext_int0_enable, ext_int1_enable} = '0;
    {ext_int0_trigger_select, ext_int1_trigger_select} = 2'b11;
    {wdt_enable_set, wdt_clear, wdt_reset_enable, wdt_flag_clear} = '0;
    {err_total, checks_done} = '0;
    insn_last_cycle = 1'b1;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    wait_reset(1'b0);
    chk("pc", pc_load_r, 16'h0000);
    chk("sp", sp_load_r, 8'h07);
    chk("port", port_load_r, 8'hff);
    chk("wdt_on", wdt_enabled_r, 1'b0);
    {needs_code_byte, ext_prog_mem} = 2'b11;
    count_fetch(120);
    chk("fetch", n_f[15:0], 16'd20);
    chk("strobe", n_s[15:0], 16'd20);
    chk("pc_inc", n_p[15:0], 16'd20);
    chk("opcode", n_o[15:0], 16'd10);
    chk("insn_done", n_d[15:0], 16'd10);
    {needs_code_byte, ext_prog_mem} = 2'b00;
    count_fetch(120);
    chk("fetch_int", n_f[15:0], 16'd20);
    chk("strobe_int", n_s[15:0], 16'd0);
    chk("pc_inc_skip", n_p[15:0], 16'd10);
    {ext_data_move, ext_prog_mem} = 2'b11;
    count_fetch(120);
    chk("fetch_move", n_f[15:0], 16'd10);
    chk("strobe_move", n_s[15:0], 16'd10);
    {ext_data_move, ext_prog_mem} = 2'b00;
    wr(1'b0, 8'h01);
    wait_mode(PRS_IDLE);
    chk("idle_bit", idle_request_bit_r, 1'b1);
    chk("cpu_clk", cpu_clk_en_r, 1'b0);
    chk("periph_clk", periph_clk_en_r, 1'b1);
    {global_interrupt_enable, other_int_req} = 2'b11;
    wait_mode(PRS_RUN);
    chk("idle_wake", {wake_int_r, resume_next_r}, 2'b10);
    other_int_req = 1'b0;
    chk("idle_clr", idle_request_bit_r, 1'b0);
    wr(1'b0, 8'h01);
    wait_mode(PRS_IDLE);
    prs_ext_src_inst.hold_reset(30);
    wait_reset(1'b1);
    chk("idle_rst", idle_request_bit_r, 1'b0);
    wait_reset(1'b0);
    {global_interrupt_enable, ext_int0_enable, ext_int0_trigger_select} = 3'b110;
    wr(1'b0, 8'h02);
    wait_mode(PRS_PDOWN);
    chk("pd_periph", periph_clk_en_r, 1'b0);
    prs_ext_src_inst.drive_int(1'b0, 1'b0);
    wait_mode(PRS_RUN);
    chk("pd_wake", {wake_int_r, resume_next_r}, 2'b11);
    prs_ext_src_inst.drive_int(1'b0, 1'b1);
    chk("pd_clr", powerdown_request_bit_r, 1'b0);
    global_interrupt_enable = 1'b0;
    wr(1'b0, 8'h02);
    wait_mode(PRS_PDOWN);
    prs_ext_src_inst.drive_int(1'b0, 1'b0);
    repeat (48) @(negedge ref_clk);
    chk("masked_wake", mode_r, PRS_PDOWN);
    prs_ext_src_inst.drive_int(1'b0, 1'b1);
    prs_ext_src_inst.hold_reset(30);
    wait_reset(1'b1);
    chk("pd_rst", powerdown_request_bit_r, 1'b0);
    wait_reset(1'b0);
    chk("pd_run", mode_r, PRS_RUN);
    wr(1'b1, 8'h83);
    repeat (40) @(negedge ref_clk);
    chk("swrst_refused", core_reset_r, 1'b0);
    in_loader_flash = 1'b1;
    wr(1'b1, 8'h83);
    wait_reset(1'b1);
    in_loader_flash = 1'b0;
    wait_reset(1'b0);
    chk("app_sel", app_flash_sel_r, 1'b1);
    wdt_reset_enable = 1'b1;
    wdt_enable_set = 1'b1;
    @(negedge ref_clk);
    wdt_enable_set = 1'b0;
    repeat (60) @(negedge ref_clk);
    wdt_clear = 1'b1;
    @(negedge ref_clk);
    wdt_clear = 1'b0;
    repeat (60) @(negedge ref_clk);
    chk("wdt_cleared", core_reset_r, 1'b0);
    wait_reset(1'b1);
    chk("wdt_flag", wdt_flag_r, 1'b1);
    wait_reset(1'b0);
    chk("wdt_hold", (k >= 12 && k <= 36), 1'b1);
    chk("wdt_kept", wdt_enabled_r, 1'b1);
    complete_run();
  end
endmodule
bind prs_sequencer prs_sequencer_chk prs_sequencer_chk_inst (.*);
